// >>> rtl/scld_top.sv
`timescale 1ns/1ps
`default_nettype none
module scld_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic link_data,
  output logic [scld_pkg::ADDR_W-1:0] reg_rd_addr,
  input wire logic reg_rd_impl,
  input wire logic [scld_pkg::REG_W-1:0] reg_rd_data,
  output logic locked,
  output logic bx_clk,
  output logic trig_pulse,
  output logic [scld_pkg::VAL_W-1:0] trig_tag,
  output logic flush_pulse,
  output logic cclr_pulse,
  output scld_pkg::scld_rdbk_s rdbk,
  output scld_pkg::scld_err_s err
);
  import scld_pkg::*;

  // ---------------------------------------------------------------
  // Link input synchronisers
  // ---------------------------------------------------------------
  logic lk1_q, lk2_q, lk3_q, ld1_q, ld2_q;
  wire bit_ev = lk2_q & ~lk3_q;

  // Two flops per pin, third only for link clock edge finding
  always_ff @(posedge clk) begin
    lk1_q <= link_clk;
    lk2_q <= lk1_q;
    lk3_q <= lk2_q;
    ld1_q <= link_data;
    ld2_q <= ld1_q;
  end

  // ---------------------------------------------------------------
  // Registers seen by software
  // ---------------------------------------------------------------
  logic [7:0] lock_thr_q, unlock_thr_q;
  logic [3:0] die_q;
  logic [31:0] prdata_q;
  scld_err_e last_err_q;
  logic locked_q;
  logic [3:0] lk_ch_q;

  wire ap_wr = psel & penable & pwrite;
  wire hit_lock = paddr == ADR_LOCK;
  wire hit_unlock = paddr == ADR_UNLOCK;
  wire hit_die = paddr == ADR_DIE;
  wire hit_stat = paddr == ADR_STAT;
  wire mapped = hit_lock | hit_unlock | hit_die | hit_stat;
  wire [31:0] rd_word = hit_lock ? {24'h000000, lock_thr_q} :
    hit_unlock ? {24'h000000, unlock_thr_q} :
    hit_die ? {28'h0000000, die_q} :
    hit_stat ? {23'h000000, last_err_q, lk_ch_q, locked_q} : 32'h00000000;

  // Zero-wait slave: error answer on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  // Read data captured in setup phase; zero threshold writes ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_thr_q <= LOCK_RST;
      unlock_thr_q <= UNLOCK_RST;
      die_q <= DIE_RST;
      prdata_q <= 32'h00000000;
    end else begin
      if (psel && !penable) prdata_q <= rd_word;
      if (ap_wr && hit_lock && pwdata[7:0] != 8'h00)
        lock_thr_q <= pwdata[7:0];
      if (ap_wr && hit_unlock && pwdata[7:0] != 8'h00)
        unlock_thr_q <= pwdata[7:0];
      if (ap_wr && hit_die) die_q <= pwdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Frame aligner
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] sh_q;
  logic [3:0] bitcnt_q;
  logic [CNT_W-1:0] cnt_q [N_CHAN];
  logic [N_CHAN-1:0] nz_vec;

  wire [FRAME_W-1:0] sh_d = {sh_q[FRAME_W-2:0], ld2_q};
  wire hit = bit_ev & (sh_d == SYNC_WORD);
  wire [CNT_W-1:0] cnt_c = cnt_q[bitcnt_q];
  wire [CNT_W-1:0] cnt_inc = (&cnt_c) ? cnt_c : CNT_W'(cnt_c + 1'b1);
  // lock on first channel at threshold
  wire lock_now = hit & ~locked_q & (cnt_inc >= lock_thr_q);
  wire hit_lk = hit & locked_q & (bitcnt_q == lk_ch_q);
  // another channel at unlock threshold drops lock
  wire unlock_now = hit & locked_q & (bitcnt_q != lk_ch_q) &
    (cnt_inc >= unlock_thr_q);
  wire [N_CHAN-1:0] chan_sel = N_CHAN'(1) << bitcnt_q;
  wire [N_CHAN-1:0] clr_mask = (lock_now | hit_lk) ? ~chan_sel : '0;
  wire [3:0] ph = bitcnt_q - lk_ch_q;
  wire frame_bit = bit_ev & locked_q & (ph == 4'h0);

  // Shift register and bit position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_q <= '0;
      bitcnt_q <= 4'h0;
    end else if (bit_ev) begin
      sh_q <= sh_d;
      bitcnt_q <= bitcnt_q + 4'h1;
    end
  end

  // one saturating sync counter per alignment
  for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q[i] <= '0;
      end else if (clr_mask[i]) begin
        cnt_q[i] <= '0;
      end else if (hit && bitcnt_q == 4'(i)) begin
        cnt_q[i] <= cnt_inc;
      end
    end
    assign nz_vec[i] = cnt_q[i] != '0;
  end

  // Lock state and adopted channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
      lk_ch_q <= 4'h0;
    end else if (lock_now) begin
      locked_q <= 1'b1;
      lk_ch_q <= bitcnt_q;
    end else if (unlock_now) begin
      locked_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Crossing clock and execution timing
  // ---------------------------------------------------------------
  logic bx_q;
  wire bx_rise = bit_ev & locked_q & (ph[1:0] == 2'b01);
  wire exec = bx_rise & (ph == EXEC_PH);

  // 1100 pattern, phase fixed to the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bx_q <= 1'b0;
    end else if (bit_ev) begin
      bx_q <= locked_q & BX_PATTERN[4'h0 - ph];
    end
  end

  // ---------------------------------------------------------------
  // Command decoder
  // ---------------------------------------------------------------
  logic frame_ev_q;
  logic [FRAME_W-1:0] fr_q;
  scld_state_e st_q, st_d;
  logic [1:0] rem_q, rem_d;
  logic [PAY_W-1:0] pay_q, pay_d;
  scld_err_e ferr;
  logic set_trig, set_flush, set_cclr, set_rd;

  // only locked-channel frames reach the decoder
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_ev_q <= 1'b0;
      fr_q <= '0;
    end else begin
      frame_ev_q <= frame_bit;
      if (frame_bit) fr_q <= sh_d;
    end
  end

  wire [7:0] sa = fr_q[15:8];
  wire [7:0] sb = fr_q[7:0];
  wire scld_kind_e ka = scld_kind(sa);
  wire scld_kind_e kb = scld_kind(sb);
  wire [VAL_W-1:0] va = scld_val(sa);
  wire [VAL_W-1:0] vb = scld_val(sb);
  wire is_sync = fr_q == SYNC_WORD;
  wire bad_sync = (ka == K_SYNC && kb == K_BAD) ||
    (ka == K_BAD && kb == K_SYNC);
  wire has_cmd = ka == K_CMD || kb == K_CMD;
  wire both_cmd = ka == K_CMD && kb == K_CMD;
  wire [7:0] cmd_sym = (ka == K_CMD) ? sa : sb;
  wire flush_or_clr = cmd_sym == CMD_FLUSH || cmd_sym == CMD_CCLR;
  wire one_bad = ka == K_BAD || kb == K_BAD;
  wire both_bad = ka == K_BAD && kb == K_BAD;
  wire any_data = ka == K_DATA || kb == K_DATA;
  wire both_data = ka == K_DATA && kb == K_DATA;
  // readback output only on die match or broadcast
  wire rd_match = pay_d[19] | (pay_d[18:15] == die_q);

  // Frame interpretation against expectation
  always_comb begin
    st_d = st_q;
    rem_d = rem_q;
    pay_d = pay_q;
    ferr = E_NONE;
    set_trig = 1'b0;
    set_flush = 1'b0;
    set_cclr = 1'b0;
    set_rd = 1'b0;
    // each frame must be sync or a valid pair
    if (frame_ev_q && !is_sync) begin
      if (bad_sync) begin
        ferr = E_CORRUPT_SYNC;
      end else if (ka == K_TRIG) begin
        set_trig = 1'b1;
        if (kb != K_DATA) ferr = E_LOST_TAG;
      end else if (has_cmd) begin
        // flush and clear pass a pending readback
        if (both_cmd && st_q == S_DATA && !flush_or_clr) begin
          ferr = E_IGNORED;
        end else begin
          if (one_bad) ferr = E_EXEC_WARN;
          set_flush = cmd_sym == CMD_FLUSH;
          set_cclr = cmd_sym == CMD_CCLR;
          if (cmd_sym == CMD_READBACK) begin
            st_d = S_DATA;
            rem_d = RD_FRAMES;
          end
        end
      end else if (st_q == S_DATA) begin
        // data frames join the pending command
        if (both_data) begin
          pay_d = {pay_q[PAY_W-11:0], va, vb};
          rem_d = rem_q - 2'h1;
          if (rem_q == 2'h1) begin
            st_d = S_IDLE;
            set_rd = 1'b1;
          end
        end else begin
          ferr = E_ABORT;
          st_d = S_IDLE;
        end
      end else if (both_bad) begin
        ferr = E_CORRUPT_FRAME;
      end else if (one_bad && any_data) begin
        ferr = E_LOST_TRIG;
      end
    end
  end

  // Decoder state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      rem_q <= 2'h0;
      pay_q <= '0;
    end else begin
      st_q <= st_d;
      rem_q <= rem_d;
      pay_q <= pay_d;
    end
  end

  // ---------------------------------------------------------------
  // Pending actions and outputs
  // ---------------------------------------------------------------
  logic [3:0] pend_trig_q, trig_sh_q;
  logic [VAL_W-1:0] pend_tag_q, trig_tag_q;
  logic pend_flush_q, pend_cclr_q, pend_rd_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic trig_q, flush_q, cclr_q;
  scld_rdbk_s rb_q;
  scld_err_s err_q;
  wire rd_impl = reg_rd_impl | (pend_addr_q == '0);

  // Pending actions wait for the execution edge
  always_ff @(posedge clk) begin
    if (!rst_n || exec) begin
      pend_trig_q <= 4'h0;
      pend_tag_q <= '0;
      pend_flush_q <= 1'b0;
      pend_cclr_q <= 1'b0;
      pend_rd_q <= 1'b0;
      pend_addr_q <= '0;
    end else if (frame_ev_q) begin
      pend_trig_q <= set_trig ? sa[3:0] : 4'h0;
      // tag 0 replaces a lost tag
      pend_tag_q <= (kb == K_DATA) ? vb : '0;
      pend_flush_q <= set_flush;
      pend_cclr_q <= set_cclr;
      pend_rd_q <= set_rd & rd_match;
      pend_addr_q <= pay_d[14:6];
    end
  end

  // outputs change on the second crossing edge after the frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
      trig_sh_q <= 4'h0;
      trig_tag_q <= '0;
      flush_q <= 1'b0;
      cclr_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      flush_q <= exec & pend_flush_q;
      cclr_q <= exec & pend_cclr_q;
      // pattern bits on four consecutive crossing edges
      if (exec && pend_trig_q != 4'h0) begin
        trig_q <= pend_trig_q[3];
        trig_sh_q <= {pend_trig_q[2:0], 1'b0};
        trig_tag_q <= pend_tag_q;
      end else if (bx_rise) begin
        trig_q <= trig_sh_q[3];
        trig_sh_q <= {trig_sh_q[2:0], 1'b0};
      end
    end
  end

  // readback result, zero and warning for unused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rb_q <= '0;
      err_q <= '{valid: 1'b0, code: E_NONE};
      last_err_q <= E_NONE;
    end else begin
      rb_q.valid <= exec & pend_rd_q;
      if (exec && pend_rd_q) begin
        rb_q.addr <= pend_addr_q;
        // address zero is the pixel portal
        rb_q.pixel <= pend_addr_q == '0;
        rb_q.warn <= ~rd_impl;
        rb_q.value <= rd_impl ? reg_rd_data : '0;
      end
      if (exec && pend_rd_q && !rd_impl) begin
        err_q <= '{valid: 1'b1, code: E_UNUSED_REG};
        last_err_q <= E_UNUSED_REG;
      end else begin
        err_q <= '{valid: ferr != E_NONE, code: ferr};
        if (ferr != E_NONE) last_err_q <= ferr;
      end
    end
  end

  assign reg_rd_addr = pend_addr_q;
  assign locked = locked_q;
  assign bx_clk = bx_q;
  assign trig_pulse = trig_q;
  assign trig_tag = trig_tag_q;
  assign flush_pulse = flush_q;
  assign cclr_pulse = cclr_q;
  assign rdbk = rb_q;
  assign err = err_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire oth_nz = |(nz_vec & ~(N_CHAN'(1) << lk_ch_q));

  a_feed_locked: assert property (
    frame_ev_q |-> $past(locked_q)) else $error("frame while unlocked");
  a_lock_cause: assert property (
    $rose(locked_q) |-> $past(hit) && !oth_nz)
    else $error("lock without sync or others kept");
  a_unlock_cause: assert property (
    $fell(locked_q) |-> $past(hit) && $past(bitcnt_q) != $past(lk_ch_q))
    else $error("lock dropped without foreign sync");
  a_thr_nonzero: assert property (
    lock_thr_q != 8'h00 && unlock_thr_q != 8'h00)
    else $error("zero threshold");
  a_bx_shape: assert property (
    bit_ev && locked_q && ph == 4'h1 |=> bx_q ##0 !$past(bx_q, 1) ||
    $past(bx_q, 1) == 1'b0) else $error("crossing clock not high");
  a_exec_edge: assert property (
    flush_q || cclr_q || rb_q.valid |-> $rose(bx_q))
    else $error("execution off the crossing edge");
  a_trig_first: assert property (
    exec && pend_trig_q != 4'h0 |=> trig_q == $past(pend_trig_q[3]))
    else $error("first trigger pulse wrong");
  a_unused_zero: assert property (
    rb_q.valid && rb_q.warn |-> rb_q.value == '0 &&
    err_q.code == E_UNUSED_REG) else $error("unused address not zero");
  a_portal_addr0: assert property (
    rb_q.valid && rb_q.addr == '0 |-> rb_q.pixel && !rb_q.warn)
    else $error("address zero not portal");
  a_lost_tag: assert property (
    err_q.valid && err_q.code == E_LOST_TAG |-> pend_tag_q == '0)
    else $error("lost tag not zero");
  a_abort_idle: assert property (
    err_q.valid && err_q.code == E_ABORT |-> st_q == S_IDLE)
    else $error("abort kept expecting data");

  c_lock: cover property ($rose(locked_q));
  c_readback: cover property (rb_q.valid);
  c_trigger: cover property (exec && pend_trig_q == 4'hF);

endmodule
`default_nettype wire

// >>> include/scld_pkg.sv
`default_nettype none
package scld_pkg;

  // ---------------------------------------------------------------
  // Widths and link framing
  // ---------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int SYM_W = 8;
  localparam int VAL_W = 5;
  localparam int ADDR_W = 9;
  localparam int REG_W = 16;
  localparam int CNT_W = 8;
  localparam int PAY_W = 20;
  localparam int N_CHAN = 16;

  // Sync word and command symbols, chosen outside the data alphabet
  localparam logic [15:0] SYNC_WORD = 16'hF00F;
  localparam logic [7:0] CMD_FLUSH = 8'h5A;
  localparam logic [7:0] CMD_CCLR = 8'h59;
  localparam logic [7:0] CMD_NOOP = 8'h69;
  localparam logic [7:0] CMD_READBACK = 8'h66;
  localparam logic [3:0] TRIG_NIB = 4'h2;
  localparam logic [1:0] RD_FRAMES = 2'h2;
  localparam logic [15:0] BX_PATTERN = 16'hCCCC;

  // Execution delay after frame end, at the nominal 160 MHz bit rate
  localparam int LINK_MHZ = 160;
  localparam int EXEC_NS = 25;
  localparam int EXEC_BITS = (EXEC_NS * LINK_MHZ + 999) / 1000;
  localparam logic [3:0] EXEC_PH = 4'(EXEC_BITS + 1);

  // Register map and reset values
  localparam logic [7:0] ADR_LOCK = 8'h00;
  localparam logic [7:0] ADR_UNLOCK = 8'h04;
  localparam logic [7:0] ADR_DIE = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [7:0] LOCK_RST = 8'h10;
  localparam logic [7:0] UNLOCK_RST = 8'h08;
  localparam logic [3:0] DIE_RST = 4'h0;

  // Balanced symbols, indexed by their 5-bit value
  localparam logic [7:0] DATA_SYM [32] = '{
    8'h6A, 8'h6C, 8'h71, 8'h72, 8'h74, 8'h8B, 8'h8D, 8'h8E,
    8'h93, 8'h95, 8'h96, 8'h99, 8'h9A, 8'h9C, 8'hA3, 8'hA5,
    8'hA6, 8'hA9, 8'hAA, 8'hAC, 8'hB1, 8'hB2, 8'hB4, 8'hC3,
    8'hC5, 8'hC6, 8'hC9, 8'hCA, 8'hCC, 8'hD1, 8'hD2, 8'hD4};

  typedef enum logic [2:0] {K_DATA, K_SYNC, K_TRIG, K_CMD, K_BAD}
    scld_kind_e;
  typedef enum logic [3:0] {E_NONE, E_ABORT, E_LOST_TRIG, E_CORRUPT_FRAME,
    E_CORRUPT_SYNC, E_EXEC_WARN, E_LOST_TAG, E_IGNORED, E_UNUSED_REG}
    scld_err_e;
  typedef enum logic {S_IDLE, S_DATA} scld_state_e;

  typedef struct packed {
    logic valid;
    scld_err_e code;
  } scld_err_s;

  typedef struct packed {
    logic valid;
    logic pixel;
    logic warn;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] value;
  } scld_rdbk_s;

  // Symbol to 5-bit value; 0 when not a data symbol
  function automatic logic [VAL_W-1:0] scld_val(input logic [7:0] s);
    logic [VAL_W-1:0] v;
    v = '0;
    for (int i = 0; i < 32; i++) begin
      if (DATA_SYM[i] == s) begin
        v = VAL_W'(i);
      end
    end
    return v;
  endfunction

  // Classify one symbol
  function automatic scld_kind_e scld_kind(input logic [7:0] s);
    logic dat;
    dat = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (DATA_SYM[i] == s) begin
        dat = 1'b1;
      end
    end
    if (dat) return K_DATA;
    if (s == SYNC_WORD[15:8] || s == SYNC_WORD[7:0]) return K_SYNC;
    if (s[7:4] == TRIG_NIB && s[3:0] != 4'h0) return K_TRIG;
    if (s == CMD_FLUSH || s == CMD_CCLR || s == CMD_NOOP ||
        s == CMD_READBACK)
      return K_CMD;
    return K_BAD;
  endfunction

endpackage
`default_nettype wire

// >>> tb/scld_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scld_ctrl_model (
  output logic link_clk,
  output logic link_data
);
  int nbits = 0;

  // ----------------------------------------
  // Serial command driver
  // ----------------------------------------
  // Idle: clock stands still, data parked low
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end

  // sixteen-bit frames, MSB first
  // Top n bits of w on a 160 ns clock; data moves while the clock is low
  // and is inverted after the last bit so no stale value lingers
  task automatic send(input logic [15:0] w, input int n);
    #7;
    for (int i = 15; i > 15 - n; i--) begin
      link_data = w[i];
      #80 link_clk = 1'b1;
      nbits++;
      #80 link_clk = 1'b0;
    end
    link_data = ~link_data;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_scld_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("MISMATCH %0t case %0d: %h vs %h", $time, k, (a), (b)); \
    end \
  end
module tb_scld_top;
  import scld_pkg::*;
  typedef struct {
    logic [3:0][15:0] f;
    int flush, cclr, trig;
    logic [4:0] tag;
    logic [3:0] err;
    int rv;
    logic [15:0] val;
    logic warn, pix;
  } scld_row_s;
  localparam logic [15:0] SY = SYNC_WORD;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, ev, link_clk, link_data, reg_rd_impl;
  logic [8:0] reg_rd_addr;
  logic [15:0] reg_rd_data;
  logic locked, bx_clk, trig_pulse, flush_pulse, cclr_pulse, bx_q, lk_q, unl;
  logic [4:0] trig_tag;
  logic [3:0] ec;
  scld_rdbk_s rdbk, rd_q;
  scld_err_s err;
  int mismatches = 0;
  int tests_run = 0;
  int k = 0;
  int n_flush, n_cclr, n_trig, n_rv, n_bx, nb0, nb_flush;
  scld_row_s rows [18];

  always #10 clk = ~clk;

  // Register store stand-in: the low 256 addresses exist
  assign reg_rd_impl = (reg_rd_addr < 9'h100);
  assign reg_rd_data = {7'h52, reg_rd_addr};

  scld_top scld_top_i (.clk(clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_data(link_data), .reg_rd_addr(reg_rd_addr),
    .reg_rd_impl(reg_rd_impl), .reg_rd_data(reg_rd_data), .locked(locked),
    .bx_clk(bx_clk), .trig_pulse(trig_pulse), .trig_tag(trig_tag),
    .flush_pulse(flush_pulse), .cclr_pulse(cclr_pulse), .rdbk(rdbk),
    .err(err));
  scld_ctrl_model scld_ctrl_model_i (.link_clk(link_clk),
    .link_data(link_data));

  // Count decoder pulses, keep last error and readback
  always @(posedge clk) begin
    bx_q <= bx_clk;
    lk_q <= locked;
    if (trig_pulse === 1'b1) n_trig++;
    if (cclr_pulse === 1'b1) n_cclr++;
    if (flush_pulse === 1'b1) begin
      n_flush++;
      nb_flush = scld_ctrl_model_i.nbits;
    end
    if (rdbk.valid === 1'b1) begin
      n_rv++;
      rd_q = rdbk;
    end
    if (err.valid === 1'b1) ec = err.code;
    if (bx_clk === 1'b1 && bx_q === 1'b0) n_bx++;
    if (locked === 1'b0 && lk_q === 1'b1) unl = 1'b1;
  end

  // ----------------------------------------
  // Bus and link helpers
  // ----------------------------------------
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask

  function automatic logic [3:0][15:0] one(input logic [15:0] w);
    return {w, SY, SY, SY};
  endfunction

  // Readback command, a middle frame, then the 20-bit payload
  function automatic logic [3:0][15:0] rdf(input logic b,
      input logic [3:0] d, input logic [8:0] a, input logic [15:0] m);
    logic [19:0] p;
    p = {b, d, a, 6'h00};
    return {CMD_READBACK, CMD_READBACK, m, DATA_SYM[p[19:15]],
      DATA_SYM[p[14:10]], DATA_SYM[p[9:5]], DATA_SYM[p[4:0]]};
  endfunction

  // Send four frames plus trailing syncs, then compare all effects
  task automatic run(input scld_row_s r);
    n_flush = 0;
    n_cclr = 0;
    n_trig = 0;
    n_rv = 0;
    n_bx = 0;
    ec = 4'h0;
    nb0 = scld_ctrl_model_i.nbits;
    for (int i = 3; i >= 0; i--) scld_ctrl_model_i.send(r.f[i], 16);
    // syncs when idle, one trigger per burst
    repeat (2) scld_ctrl_model_i.send(SY, 16);
    repeat (20) @(posedge clk);
    `CHK(n_flush, r.flush)
    `CHK(n_cclr, r.cclr)
    `CHK(n_trig, r.trig)
    if (r.trig > 0) `CHK(trig_tag, r.tag)
    `CHK(ec, r.err)
    `CHK(n_rv, r.rv)
    if (r.rv > 0) `CHK(rd_q.value, r.val)
    if (r.rv > 0) `CHK({rd_q.warn, rd_q.pixel}, {r.warn, r.pix})
    if (locked === 1'b1) `CHK(n_bx, 24)
  endtask

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rows = '{
      '{one(16'h5A5A), 1, 0, 0, 5'h00, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h5959), 0, 1, 0, 5'h00, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h6969), 0, 0, 0, 5'h00, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h2F8E), 0, 0, 4, 5'h07, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h21D4), 0, 0, 1, 5'h1F, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h2A6A), 0, 0, 2, 5'h00, 4'h0, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h5A00), 1, 0, 0, 5'h00, 4'h5, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h2F00), 0, 0, 4, 5'h00, 4'h6, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h008E), 0, 0, 0, 5'h00, 4'h2, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'h0000), 0, 0, 0, 5'h00, 4'h3, 0, 16'h0000, 1'b0, 1'b0},
      '{one(16'hF000), 0, 0, 0, 5'h00, 4'h4, 0, 16'h0000, 1'b0, 1'b0},
      '{{16'h6666, 16'h008E, SY, SY}, 0, 0, 0, 5'h00, 4'h1, 0, 16'h0000,
        1'b0, 1'b0},
      '{rdf(1'b0, 4'h0, 9'h005, SY), 0, 0, 0, 5'h00, 4'h0, 1, 16'hA405,
        1'b0, 1'b0},
      '{rdf(1'b0, 4'h0, 9'h000, SY), 0, 0, 0, 5'h00, 4'h0, 1, 16'hA400,
        1'b0, 1'b1},
      '{rdf(1'b0, 4'h0, 9'h1F0, SY), 0, 0, 0, 5'h00, 4'h8, 1, 16'h0000,
        1'b1, 1'b0},
      '{rdf(1'b0, 4'h3, 9'h005, SY), 0, 0, 0, 5'h00, 4'h0, 0, 16'h0000,
        1'b0, 1'b0},
      '{rdf(1'b1, 4'h3, 9'h005, SY), 0, 0, 0, 5'h00, 4'h0, 1, 16'hA405,
        1'b0, 1'b0},
      '{rdf(1'b0, 4'h0, 9'h005, 16'h5A5A), 1, 0, 0, 5'h00, 4'h0, 1,
        16'hA405, 1'b0, 1'b0}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    k = 100;
    rchk(8'h00, 32'h10);
    rchk(8'h04, 32'h08);
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h00, 32'h10);
    apb(1'b1, 8'h0C, 32'hF);
    rchk(8'h0C, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK({ev, rdv}, 33'h1_0000_0000)
    apb(1'b1, 8'h00, 32'h4);
    rchk(8'h00, 32'h4);
    k = 101;
    run('{{16'h5A5A, 16'h5959, 16'h2F8E, 16'h6969}, 0, 0, 0, 5'h00, 4'h0,
      0, 16'h0000, 1'b0, 1'b0});
    scld_ctrl_model_i.send(SY, 16);
    repeat (20) @(posedge clk);
    `CHK(locked, 1'b0)
    scld_ctrl_model_i.send(SY, 16);
    repeat (20) @(posedge clk);
    `CHK(locked, 1'b1)
    rchk(8'h0C, {23'h0, 4'h0, 4'hF, 1'b1});
    for (k = 0; k < 18; k++) run(rows[k]);
    k = 200;
    apb(1'b1, 8'h08, 32'h3);
    run('{rdf(1'b0, 4'h3, 9'h005, SY), 0, 0, 0, 5'h00, 4'h0, 1, 16'hA405,
      1'b0, 1'b0});
    `CHK(rd_q.addr, 9'h005)
    k = 203;
    run('{rdf(1'b0, 4'h3, 9'h005, 16'h6969), 0, 0, 0, 5'h00, 4'h7, 1,
      16'hA405, 1'b0, 1'b0});
    k = 201;
    run(rows[0]);
    `CHK(nb_flush - nb0, 21)
    k = 202;
    unl = 1'b0;
    scld_ctrl_model_i.send(SY, 8);
    repeat (9) scld_ctrl_model_i.send(SY, 16);
    repeat (20) @(posedge clk);
    `CHK(unl, 1'b1)
    repeat (2) scld_ctrl_model_i.send(SY, 16);
    repeat (20) @(posedge clk);
    `CHK(locked, 1'b1)
    run(rows[0]);
    summarize();
  end

  // Cut a hang short well past the expected run time
  initial begin
    #1_000_000;
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
